/* core/gpbm_params.svh */
// Constants for the general-purpose parallel bus master.
// Assumes inclusion by core/gpbm_pkg.sv and the bus master module only.
`ifndef GPBM_PARAMS_SVH
`define GPBM_PARAMS_SVH

// Host address bits that form the peripheral address
`define GPBM_HADDR_HI      7
`define GPBM_HADDR_LO      2
// Both low halfword lanes, and no others, must be enabled (active-high enables here)
`define GPBM_BE_VALID      4'h3
// Reset value of the address and data lines; later idle periods keep the last access's values
`define GPBM_IDLE_ADDR     6'h00
`define GPBM_IDLE_DATA     16'h0000
// Strobe lasts at least this many cycles before ready is looked at
`define GPBM_STROBE_MIN    2'h1

`endif

/* core/gpbm_pkg.sv */
// Types for the general-purpose parallel bus master.
// Assumes the params header sits in the same folder.
`include "gpbm_params.svh"

package gpbm_pkg;

    typedef enum logic [2:0] {
        GPBM_IDLE,
        GPBM_SETUP,
        GPBM_STROBE,
        GPBM_HOLD,
        GPBM_DONE
    } gpbm_state_e;

    // One host request
    typedef struct packed {
        logic        write;
        logic [31:0] addr;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } gpbm_req_s;

    // Answer back to the host
    typedef struct packed {
        logic        done;
        logic        error;
        logic [31:0] rdata;
    } gpbm_rsp_s;

endpackage

/* core/gpbm_master.sv */
// Sequencer that turns single host reads and writes into select/strobe
// accesses on a 16-bit data, 6-bit address parallel bus.
// Assumes a host that holds req stable while req_valid is high and busy is low,
// and a peripheral that drives periph_data only while the read strobe is low.
//
// Behaviour
// - Idle: select and strobes high, address and data driven stable.
// - Write start: select low, drive write word and translated address.
// - After select and data settle, drive write strobe low.
// - Write data unchanged across both edges of the write strobe.
// - Sample ready before releasing write strobe; low level means ready.
// - Every access ends with select high after the strobe is released.
// - Read start: select low, data drivers off, address driven.
// - After select and data release, drive read strobe low.
// - Ready sampled asserted: raise read strobe and capture the data.
// - Ready not asserted: keep read strobe low until ready seen.
// - After a read, drive address and data lines again.
// - Peripheral address is host address bits seven down to two.
// - Only the low halfword byte-enable pattern is valid.
// - Peripheral reset output follows the global reset input.
`timescale 1ns/1ps

`include "gpbm_params.svh"

module gpbm_master
    import gpbm_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      arst_n,
    input  wire logic      global_reset_n,
    input  wire logic      req_valid,
    input  wire gpbm_req_s req,
    output gpbm_rsp_s      rsp_q,
    output logic           busy_q,
    output logic           periph_select_n_q,
    output logic           periph_write_strobe_n_q,
    output logic           periph_read_strobe_n_q,
    output logic [5:0]     periph_addr_q,
    output logic [15:0]    periph_data_out_q,
    output logic           periph_data_oe_n_q,
    input  wire logic [15:0] periph_data_in,
    input  wire logic      periph_ready,
    output logic           periph_reset_n_q
);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic        rdy_meta_q;
    logic        rdy_sync_q;
    logic        global_reset_n_meta_q;
    logic        global_reset_n_sync_q;
    logic [15:0] din_meta_q;
    logic [15:0] din_sync_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdy_meta_q  <= 1'b1;
            rdy_sync_q  <= 1'b1;
            global_reset_n_meta_q <= 1'b0;
            global_reset_n_sync_q <= 1'b0;
            din_meta_q  <= `GPBM_IDLE_DATA;
            din_sync_q  <= `GPBM_IDLE_DATA;
        end else begin
            rdy_meta_q  <= periph_ready;
            rdy_sync_q  <= rdy_meta_q;
            global_reset_n_meta_q <= global_reset_n;
            global_reset_n_sync_q <= global_reset_n_meta_q;
            din_meta_q  <= periph_data_in;
            din_sync_q  <= din_meta_q;
        end
    end

    // Ready is active low on the pin
    logic ready_seen;
    assign ready_seen = !rdy_sync_q;

    // ==========================================================
    // Peripheral reset
    // ==========================================================
    // Asserted by either reset; release waits for the synchronised input
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            periph_reset_n_q <= 1'b0;
        end else begin
            periph_reset_n_q <= global_reset_n_sync_q;
        end
    end

    // ==========================================================
    // Access sequencer
    // ==========================================================
    gpbm_state_e state_q;
    logic        is_write_q;
    logic [1:0]  strobe_cnt_q;

    function automatic logic be_ok(input logic [3:0] be);
        return be == `GPBM_BE_VALID;
    endfunction

    logic take;
    assign take = (state_q == GPBM_IDLE) && req_valid && global_reset_n_sync_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q      <= GPBM_IDLE;
            is_write_q   <= 1'b0;
            strobe_cnt_q <= 2'h0;
        end else begin
            unique case (state_q)
                GPBM_IDLE: begin
                    if (take && be_ok(req.byte_en)) begin
                        state_q    <= GPBM_SETUP;
                        is_write_q <= req.write;
                    end
                end
                GPBM_SETUP: begin
                    state_q      <= GPBM_STROBE;
                    strobe_cnt_q <= 2'h0;
                end
                GPBM_STROBE: begin
                    if (strobe_cnt_q < `GPBM_STROBE_MIN) begin
                        strobe_cnt_q <= strobe_cnt_q + 2'h1;
                    end else if (ready_seen) begin
                        state_q <= GPBM_HOLD;
                    end
                end
                GPBM_HOLD: state_q <= GPBM_DONE;
                GPBM_DONE: state_q <= GPBM_IDLE;
                default:   state_q <= GPBM_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Bus pins
    // ==========================================================
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            periph_select_n_q       <= 1'b1;
            periph_write_strobe_n_q <= 1'b1;
            periph_read_strobe_n_q  <= 1'b1;
            periph_addr_q           <= `GPBM_IDLE_ADDR;
            periph_data_out_q       <= `GPBM_IDLE_DATA;
            periph_data_oe_n_q      <= 1'b0;
        end else begin
            if (take && be_ok(req.byte_en)) begin
                periph_select_n_q  <= 1'b0;
                periph_addr_q      <= req.addr[`GPBM_HADDR_HI:`GPBM_HADDR_LO];
                periph_data_out_q  <= req.wdata[15:0];
                periph_data_oe_n_q <= !req.write;
            end
            if (state_q == GPBM_SETUP) begin
                periph_write_strobe_n_q <= !is_write_q;
                periph_read_strobe_n_q  <= is_write_q;
            end
            if (state_q == GPBM_STROBE && strobe_cnt_q >= `GPBM_STROBE_MIN && ready_seen) begin
                periph_write_strobe_n_q <= 1'b1;
                periph_read_strobe_n_q  <= 1'b1;
            end
            if (state_q == GPBM_HOLD) begin
                periph_select_n_q  <= 1'b1;
                periph_data_oe_n_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Host answer
    // ==========================================================
    // Read data is the synchronised copy and trails the pins by two edges, so it is
    // taken in the done state: that is the word that stood as the strobe was raised.
    // Taking it a cycle earlier would catch a nominal peripheral before its data is valid.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_q  <= '0;
            busy_q <= 1'b0;
        end else begin
            rsp_q.done  <= 1'b0;
            rsp_q.error <= 1'b0;
            if (take && !be_ok(req.byte_en)) begin
                rsp_q.done  <= 1'b1;
                rsp_q.error <= 1'b1;
            end
            if (state_q == GPBM_DONE) begin
                rsp_q.done <= 1'b1;
                if (!is_write_q) begin
                    rsp_q.rdata <= {16'h0000, din_sync_q};
                end
            end
            busy_q <= (take && be_ok(req.byte_en)) ||
                      (state_q != GPBM_IDLE && state_q != GPBM_DONE);
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence s_strobe_low;
        !periph_write_strobe_n_q || !periph_read_strobe_n_q;
    endsequence

    chk_idle_quiet: assert property (
        state_q == GPBM_IDLE && $past(state_q) == GPBM_DONE |->
        periph_select_n_q && periph_write_strobe_n_q && periph_read_strobe_n_q
        && !periph_data_oe_n_q)
        else $error("idle bus not quiet");
    chk_start_select: assert property (
        take && be_ok(req.byte_en) |=> !periph_select_n_q
        && periph_data_oe_n_q == !is_write_q && periph_write_strobe_n_q)
        else $error("access start wrong");
    chk_wr_strobe: assert property (
        state_q == GPBM_SETUP && is_write_q |=> !periph_write_strobe_n_q)
        else $error("write strobe not asserted");
    chk_rd_strobe: assert property (
        state_q == GPBM_SETUP && !is_write_q |=> !periph_read_strobe_n_q
        && periph_data_oe_n_q)
        else $error("read strobe not asserted");
    chk_wdata_stable: assert property (
        s_strobe_low |=> $stable(periph_data_out_q) && $stable(periph_addr_q))
        else $error("data moved during strobe");
    chk_wait_ready: assert property (
        $rose(periph_write_strobe_n_q) || $rose(periph_read_strobe_n_q) |->
        $past(ready_seen))
        else $error("strobe released without ready");
    chk_select_end: assert property (
        $rose(periph_select_n_q) |-> $past(periph_write_strobe_n_q)
        && $past(periph_read_strobe_n_q))
        else $error("select released before strobe");
    chk_read_done: assert property (
        $rose(periph_read_strobe_n_q) |=> ##1 rsp_q.done && !periph_data_oe_n_q)
        else $error("read did not finish");
    chk_addr_map: assert property (
        take && be_ok(req.byte_en) |=>
        periph_addr_q == $past(req.addr[`GPBM_HADDR_HI:`GPBM_HADDR_LO]))
        else $error("peripheral address wrong");
    chk_bad_be: assert property (
        take && !be_ok(req.byte_en) |=> rsp_q.error && periph_select_n_q)
        else $error("bad lanes not refused");
    chk_reset_out: assert property (
        !global_reset_n_sync_q |=> !periph_reset_n_q)
        else $error("peripheral reset not following");

endmodule

/* dv/gpbm_periph_model.sv */
// Behavioural peripheral for the parallel bus: captures writes, answers reads.
// Assumes strobes and select are active low and driven by the bus master.
`timescale 1ns/1ps

module gpbm_periph_model (
    input  wire logic        mclk,
    input  wire logic        sel_n,
    input  wire logic        wr_n,
    input  wire logic        rd_n,
    input  wire logic [5:0]  addr,
    input  wire logic [15:0] dout,
    input  wire logic [3:0]  waits,
    output logic [15:0]      din,
    output logic             ready,
    output logic [15:0]      got_data,
    output logic [5:0]       got_addr
);
    logic [3:0] cnt;

    initial begin
        din = 16'h0000;
        ready = 1'b0;
        got_data = 16'h0000;
        got_addr = 6'h00;
        cnt = 4'h0;
    end

    // ==========================================================
    // Write capture
    always @(posedge wr_n) begin
        if (sel_n === 1'b0) begin
            got_data <= dout;
            got_addr <= addr;
        end
    end

    // ==========================================================
    // Read data and ready
    // Lines are floating outside the strobe, so show a toggling value
    always @(posedge mclk) begin
        din <= (rd_n === 1'b0 && sel_n === 1'b0) ? {4'ha, addr, 6'h15} : ~din;
        if (sel_n !== 1'b0) begin
            cnt <= 4'h0;
            ready <= (waits != 4'h0);
        end else if (cnt < waits) begin
            cnt <= cnt + 4'h1;
            ready <= 1'b1;
        end else begin
            ready <= 1'b0;
        end
    end
endmodule

/* dv/test_general_purpose_bus_master.sv */
// Self-checking bench: host-side tasks drive the master, a model sits on the bus.
// Assumes core/gpbm_pkg.sv and core/gpbm_master.sv are compiled first.
`timescale 1ns/1ps

module test_general_purpose_bus_master
    import gpbm_pkg::*;
;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        global_reset_n = 1'b0;
    logic        req_valid = 1'b0;
    gpbm_req_s   req = '0;
    gpbm_rsp_s   rsp_q;
    logic        busy_q, sel_n, wr_n, rd_n, oe_n, rdy, prst_n;
    logic [5:0]  paddr, got_addr;
    logic [15:0] dout, din, got_data;
    logic [3:0]  waits = 4'h0;
    int          num_errors = 0;
    int          tests_run = 0;
    int          lat, glitch, selcnt, busycnt;

    always #50 mclk = ~mclk;

    gpbm_master uut (
        .mclk(mclk), .arst_n(arst_n), .global_reset_n(global_reset_n),
        .req_valid(req_valid), .req(req), .rsp_q(rsp_q), .busy_q(busy_q),
        .periph_select_n_q(sel_n), .periph_write_strobe_n_q(wr_n),
        .periph_read_strobe_n_q(rd_n), .periph_addr_q(paddr),
        .periph_data_out_q(dout), .periph_data_oe_n_q(oe_n),
        .periph_data_in(din), .periph_ready(rdy), .periph_reset_n_q(prst_n)
    );

    gpbm_periph_model partner (
        .mclk(mclk), .sel_n(sel_n), .wr_n(wr_n), .rd_n(rd_n), .addr(paddr),
        .dout(dout), .waits(waits), .din(din), .ready(rdy),
        .got_data(got_data), .got_addr(got_addr)
    );

    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Request stands for one edge: the master is idle whenever a scenario starts, so
    // that edge takes it; a longer request would be taken again after a refused one
    task automatic access(input logic wr, input logic [31:0] a, input logic [3:0] be,
                          input logic [31:0] wd);
        lat = -1;
        glitch = 0;
        selcnt = 0;
        busycnt = 0;
        @(posedge mclk);
        req <= '{write: wr, addr: a, byte_en: be, wdata: wd};
        req_valid <= 1'b1;
        do begin
            @(posedge mclk);
            if (lat == -1) req_valid <= 1'b0;
            #1 lat++;
            if (sel_n === 1'b0) selcnt++;
            if (busy_q === 1'b1) busycnt++;
            if (wr_n === 1'b0 && dout !== wd[15:0]) glitch++;
            if (!wr && sel_n === 1'b0 && oe_n !== 1'b1) glitch++;
        end while (rsp_q.done !== 1'b1 && lat < 40);
        if (lat >= 40) begin
            num_errors++;
            close_out();
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_write(input logic [3:0] w, input logic [5:0] pa, input logic [15:0] wd);
        waits = w;
        access(1'b1, {24'h000ff0, pa, 2'b00}, 4'h3, {16'h1234, wd});
        chk("waddr", {26'h0, pa}, {26'h0, got_addr});
        chk("wdata", {16'h0, wd}, {16'h0, got_data});
        chk("wlat", 32'h1, (w == 4'h0) ? (lat == 5) : (lat > 8));
        chk("wbusy", lat, busycnt);
        chk("wstable", 32'h0, glitch);
        chk("widle", 32'he, {sel_n, wr_n, rd_n, oe_n});
        $display("write test with %0d waits finished", w);
    endtask

    task automatic t_read(input logic [3:0] w, input logic [5:0] pa);
        waits = w;
        access(1'b0, {24'h000000, pa, 2'b00}, 4'h3, 32'h0);
        chk("rdata", {16'h0, 4'ha, pa, 6'h15}, rsp_q.rdata);
        chk("rlat", 32'h1, (w == 4'h0) ? (lat == 5) : (lat > 8));
        chk("rbusy", lat, busycnt);
        chk("rrelease", 32'h0, glitch);
        chk("ridle", 32'he, {sel_n, wr_n, rd_n, oe_n});
        $display("read test with %0d waits finished", w);
    endtask

    task automatic t_bad_lanes();
        waits = 4'h0;
        access(1'b1, 32'h00000004, 4'hc, 32'h0000ffff);
        chk("err", 32'h1, rsp_q.error);
        chk("errlat", 32'h0, lat);
        chk("nobus", 32'h0, selcnt);
        chk("errbusy", 32'h0, busycnt);
        $display("lane test finished");
    endtask

    // Global reset low and back high: the peripheral reset follows, the bus stays idle
    task automatic t_periph_reset();
        @(posedge mclk);
        global_reset_n <= 1'b0;
        repeat (4) @(posedge mclk);
        #1 chk("prst_low", 32'h0, prst_n);
        @(posedge mclk);
        global_reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        #1 chk("prst_high", 32'h1, prst_n);
        chk("idle", 32'he, {sel_n, wr_n, rd_n, oe_n});
        $display("reset test finished");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        t_periph_reset();
        t_write(4'h0, 6'h2c, 16'hbbaa);
        t_read(4'h0, 6'h3f);
        t_read(4'h8, 6'h05);
        t_periph_reset();
        t_write(4'h8, 6'h13, 16'h5a3c);
        t_bad_lanes();
        close_out();
    end
endmodule
